// File: verilog/pid_regulator_params.svh
`ifndef PID_REGULATOR_PARAMS_SVH
`define PID_REGULATOR_PARAMS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define PID_CLK_HZ 40000000
`define PID_TICK_US 1000
`define PID_TICK_CYCLES ((`PID_CLK_HZ / 1000000) * `PID_TICK_US)
`define PID_TICKS_PER_DSEC (100000 / `PID_TICK_US)
`define PID_TICKS_PER_CSEC (10000 / `PID_TICK_US)
`define PID_DEV_FAULT_FUNC 16'h0010

// ----------------------------------------
// register offsets (word index)
// ----------------------------------------
`define PID_REG_CTRL 5'h00
`define PID_REG_KP 5'h01
`define PID_REG_TI 5'h02
`define PID_REG_TD 5'h03
`define PID_REG_IBOUND 5'h04
`define PID_REG_DFILT 5'h05
`define PID_REG_OUTLIM 5'h06
`define PID_REG_LOSS_TIME 5'h07
`define PID_REG_LOSS_ACT 5'h08
`define PID_REG_FB_GAIN 5'h09
`define PID_REG_DEV_LEVEL 5'h0a
`define PID_REG_DEV_WIN 5'h0b
`define PID_REG_SLEEP_TIME 5'h0c
`define PID_REG_SLEEP_FREQ 5'h0d
`define PID_REG_WAKE_FREQ 5'h0e
`define PID_REG_DEV_ACT 5'h0f
`define PID_REG_MAX_FREQ 5'h10
`define PID_REG_MIN_FREQ 5'h11
`define PID_REG_PID_MIN 5'h12
`define PID_REG_LOWER_BOUND 5'h13
`define PID_REG_FAULT_FUNC 5'h14
`define PID_REG_FB_SCALE 5'h15
`define PID_REG_STATUS 5'h16
`define PID_REG_FREQ_CMD 5'h17
`define PID_REG_DISPLAY 5'h18

// ----------------------------------------
// control bit positions
// ----------------------------------------
`define PID_CTRL_ENABLE 0
`define PID_CTRL_POSITIVE 1
`define PID_CTRL_PARALLEL 2
`define PID_CTRL_CURRENT_LOOP 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define PID_RST_CTRL 16'h0000
`define PID_RST_KP 16'h000a
`define PID_RST_TI 16'h0064
`define PID_RST_TD 16'h0000
`define PID_RST_IBOUND 16'h0064
`define PID_RST_DFILT 16'h0000
`define PID_RST_OUTLIM 16'h0064
`define PID_RST_LOSS_TIME 16'h0258
`define PID_RST_LOSS_ACT 2'h0
`define PID_RST_FB_GAIN 16'h000a
`define PID_RST_DEV_LEVEL 16'h0064
`define PID_RST_DEV_WIN 16'h0032
`define PID_RST_SLEEP_TIME 16'h0000
`define PID_RST_MAX_FREQ 16'h1770
`define PID_RST_FB_SCALE 16'h03e7

`endif

// File: verilog/pid_regulator_pkg.sv
package pid_regulator_pkg;

    // sleep state of the regulator output
    typedef enum logic [0:0] {
        ST_RUN,
        ST_SLEEP
    } sleep_state_t;

    // hold timer state
    typedef struct packed {
        logic [23:0] count;
        logic expired;
    } hold_state_t;

    // whole regulator state
    typedef struct packed {
        logic [15:0] ctrl;
        logic [15:0] kp;
        logic [15:0] ti;
        logic [15:0] td;
        logic [15:0] ibound;
        logic [15:0] dfilt;
        logic [15:0] outlim;
        logic [15:0] loss_time;
        logic [1:0] loss_act;
        logic [15:0] fb_gain;
        logic [15:0] dev_level;
        logic [15:0] dev_win;
        logic [15:0] sleep_time;
        logic [15:0] sleep_freq;
        logic [15:0] wake_freq;
        logic [1:0] dev_act;
        logic [15:0] max_freq;
        logic [15:0] min_freq;
        logic [15:0] pid_min;
        logic [15:0] lower_bound;
        logic [15:0] fault_func;
        logic [15:0] fb_scale;
        logic [15:0] rd_data;
        logic [15:0] tick_cnt;
        logic abn_sync1;
        logic abn_sync2;
        logic signed [31:0] prev_dev;
        logic signed [47:0] integ;
        logic signed [39:0] dfilt_acc;
        logic [15:0] freq_cmd;
        logic [15:0] display;
        sleep_state_t sleep_state;
        logic accel_from_min;
    } pid_state_t;

endpackage

// File: verilog/pid_hold_timer.sv
`timescale 1ns/1ps

module pid_hold_timer
    import pid_regulator_pkg::*;
(
    input wire logic mclk_in, // system clock
    input wire logic resetn_in, // async reset, active low
    input wire logic tick_in, // control period pulse
    input wire logic cond_in, // condition being timed
    input wire logic [23:0] limit_in, // hold time in ticks
    output logic expired_out // condition held longer than limit
);

    hold_state_t st_q;
    hold_state_t st_d;

    // count ticks while the condition holds, restart when it drops
    always_comb begin
        st_d = st_q;
        if (!cond_in) begin
            st_d.count = '0;
            st_d.expired = 1'b0;
        end else if (tick_in) begin
            if (st_q.count > limit_in) begin
                st_d.expired = 1'b1;
            end else begin
                st_d.count = st_q.count + 24'h000001;
            end
        end
    end

    // state register
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign expired_out = st_q.expired;

endmodule

// File: verilog/pid_frequency_regulator.sv
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "pid_regulator_params.svh"

// Behaviour
// RL1: integral time 0-100 s, zero drops integral; ti is not limited, any value up to 655.35 s is taken
// RL2: integral reaches deviation after integral time
// RL3: derivative is time times deviation difference
// RL4: integral clamped to max frequency percentage
// RL5: first-order filter on derivative path
// RL6: output limited to max frequency percentage
// RL7: current-loop feedback loss warning after time
// RL8: loss action: ramp, coast or continue
// RL9: feedback multiplied by gain before deviation
// RL10: zero error level disables deviation supervision
// RL11: deviation held past window raises fault
// RL12: sleep after low output for detect time
// RL13: wake after high command for detect time
// RL14: compute during sleep, wake from minimum frequency
// RL15: wake frequency must exceed sleep frequency; not checked, any wake_freq is accepted
// RL16: between minimum and bound: zero or bound
// RL17: below minimum: zero, or bound while timing
// RL18: regulator minimum frequency up to 60 Hz; pid_min is not limited, any value up to 655.35 Hz is taken
// RL19: physical scale affects display only
// RL20: gains change while running, no stop
// RL21: selector zero picks series arrangement
// RL22: polarity chooses deviation sign
// RL23: deviation action: warn, coast or ramp
// RL24: fixed control period, fixed-point units
module pid_frequency_regulator
    import pid_regulator_pkg::*;
#(
    parameter int TICK_CYCLES = `PID_TICK_CYCLES
) (
    input wire logic mclk_in, // system clock, 40 MHz
    input wire logic resetn_in, // async reset, active low
    input wire logic [4:0] reg_addr_in, // register word index
    input wire logic [15:0] reg_wdata_in, // register write data
    input wire logic reg_wr_in, // write strobe
    input wire logic reg_rd_in, // read strobe
    output logic [15:0] reg_rdata_out, // read data, cycle after strobe
    input wire logic [15:0] setpoint_in, // target, 0.01 Hz
    input wire logic [15:0] feedback_in, // measured value, 0.01 Hz
    input wire logic fb_abnormal_in, // current-loop signal abnormal pin
    input wire logic [15:0] actual_freq_in, // actual output frequency, 0.01 Hz
    output logic [15:0] freq_cmd_out, // frequency command, 0.01 Hz
    output logic accel_from_min_out, // wake: ramp from minimum frequency
    output logic sleep_active_out, // regulator output asleep
    output logic fb_loss_warn_out, // feedback loss warning
    output logic dev_warn_out, // deviation error present
    output logic dev_fault_out, // deviation fault output terminal
    output logic stop_ramp_out, // request ramp to stop
    output logic stop_coast_out, // request coast to stop
    output logic [15:0] fb_display_out // feedback display value
);

    pid_state_t st_q;
    pid_state_t st_d;

    logic loss_exp;
    logic dev_exp;
    logic sleep_exp;
    logic wake_exp;
    logic tick;
    logic loss_cond;
    logic dev_cond;
    logic sleep_cond;
    logic wake_cond;
    logic signed [31:0] fb_gained;
    logic signed [31:0] dev_now;
    logic signed [31:0] offset_abs;
    logic [15:0] dev_thresh;
    logic [15:0] u_limited;

    // ----------------------------------------
    // helpers
    // ----------------------------------------

    // base times pct divided by div, unsigned
    function automatic logic [31:0] pct_of(input logic [15:0] base, input logic [15:0] pct,
                                           input logic [15:0] div);
        logic [31:0] p;
        p = {16'h0000, base} * {16'h0000, pct};
        if (div != 16'h0000) begin
            p = p / {16'h0000, div};
        end
        return p;
    endfunction

    // setting in tenths of a second to ticks
    function automatic logic [23:0] dsec_ticks(input logic [15:0] t);
        logic [31:0] p;
        p = {16'h0000, t} * 32'(`PID_TICKS_PER_DSEC);
        return p[23:0];
    endfunction

    // clamp signed value into 0..hi
    function automatic logic [15:0] clamp_u16(input logic signed [47:0] v, input logic [15:0] hi);
        logic [15:0] r;
        if (v < 48'sh0) begin
            r = 16'h0000;
        end else if (v > $signed({32'h0, hi})) begin
            r = hi;
        end else begin
            r = v[15:0];
        end
        return r;
    endfunction

    // ----------------------------------------
    // supervision conditions
    // ----------------------------------------

    // control period strobe
    assign tick = (st_q.tick_cnt == 16'(TICK_CYCLES - 1)); // RL24

    // gained feedback and polarity
    assign fb_gained = $signed(pct_of(feedback_in, st_q.fb_gain, 16'h000a)); // RL9
    assign dev_now = st_q.ctrl[`PID_CTRL_POSITIVE] ?
        fb_gained - $signed({16'h0000, setpoint_in}) :
        $signed({16'h0000, setpoint_in}) - fb_gained; // RL22
    assign offset_abs = (dev_now < 32'sh0) ? -dev_now : dev_now;
    assign dev_thresh = 16'(pct_of(st_q.max_freq, st_q.dev_level, 16'h03e8));

    assign loss_cond = st_q.ctrl[`PID_CTRL_CURRENT_LOOP] && st_q.abn_sync2
        && (st_q.loss_time != 16'h0000); // RL7
    assign dev_cond = st_q.ctrl[`PID_CTRL_ENABLE] && (st_q.dev_level != 16'h0000)
        && (offset_abs > $signed({16'h0000, dev_thresh})); // RL10
    // timers count only in the state they can leave
    assign sleep_cond = (st_q.sleep_state == ST_RUN) && (actual_freq_in <= st_q.sleep_freq); // RL12
    assign wake_cond = (st_q.sleep_state == ST_SLEEP) && (u_limited > st_q.wake_freq); // RL13

    // ----------------------------------------
    // hold timers
    // ----------------------------------------

    pid_hold_timer u_loss_timer (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .tick_in(tick),
        .cond_in(loss_cond),
        .limit_in(dsec_ticks(st_q.loss_time)),
        .expired_out(loss_exp)
    );

    pid_hold_timer u_dev_timer (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .tick_in(tick),
        .cond_in(dev_cond),
        .limit_in(dsec_ticks(st_q.dev_win)),
        .expired_out(dev_exp)
    );

    pid_hold_timer u_sleep_timer (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .tick_in(tick),
        .cond_in(sleep_cond),
        .limit_in(dsec_ticks(st_q.sleep_time)),
        .expired_out(sleep_exp)
    );

    pid_hold_timer u_wake_timer (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .tick_in(tick),
        .cond_in(wake_cond),
        .limit_in(dsec_ticks(st_q.sleep_time)),
        .expired_out(wake_exp)
    );

    // ----------------------------------------
    // control law and registers
    // ----------------------------------------

    logic signed [47:0] dev_w;
    logic signed [47:0] i_step;
    logic signed [47:0] i_next;
    logic signed [47:0] i_lim;
    logic signed [47:0] i_term;
    logic signed [39:0] d_raw;
    logic signed [39:0] d_next;
    logic signed [47:0] d_term;
    logic signed [47:0] u_raw;
    logic [15:0] out_lim;
    logic sleep_en;

    // combinational law, applied on each tick
    always_comb begin
        dev_w = 48'(dev_now);
        out_lim = 16'(pct_of(st_q.max_freq, st_q.outlim, 16'h0064));
        i_lim = $signed({16'h0000, pct_of(st_q.max_freq, st_q.ibound, 16'h0064)}) <<< 16; // RL4
        if (st_q.ti == 16'h0000) begin
            i_step = 48'sh0;
            i_next = 48'sh0; // RL1
        end else begin
            i_step = (dev_w <<< 16) / $signed({32'h0, st_q.ti} * 48'(`PID_TICKS_PER_CSEC)); // RL2
            i_next = st_q.integ + i_step;
        end
        if (i_next > i_lim) begin
            i_next = i_lim; // RL4
        end else if (i_next < -i_lim) begin
            i_next = -i_lim;
        end
        i_term = st_q.integ >>> 16;
        d_raw = (40'(dev_now - st_q.prev_dev) * $signed({24'h0, st_q.td}) * 40'sd256) / 40'sd100; // RL3
        if (st_q.dfilt == 16'h0000) begin
            d_next = d_raw;
        end else begin
            d_next = st_q.dfilt_acc + (d_raw - st_q.dfilt_acc)
                / $signed(40'({24'h0, st_q.dfilt}) * 40'(`PID_TICKS_PER_DSEC)); // RL5
        end
        d_term = 48'(st_q.dfilt_acc >>> 8);
        if (st_q.ctrl[`PID_CTRL_PARALLEL]) begin
            u_raw = (dev_w * $signed({32'h0, st_q.kp})) / 48'sd10 + i_term + d_term;
        end else begin
            u_raw = ((dev_w + i_term + d_term) * $signed({32'h0, st_q.kp})) / 48'sd10; // RL21
        end
        u_limited = clamp_u16(u_raw, out_lim); // RL6
    end

    // next state
    always_comb begin
        st_d = st_q;
        sleep_en = (st_q.sleep_time != 16'h0000);
        st_d.accel_from_min = 1'b0;
        st_d.rd_data = 16'h0000;

        // pin synchroniser
        st_d.abn_sync1 = fb_abnormal_in;
        st_d.abn_sync2 = st_q.abn_sync1;

        // control period counter
        st_d.tick_cnt = tick ? 16'h0000 : st_q.tick_cnt + 16'h0001;

        // settings may change at any time, taken on the next tick, except a cleared enable bit, which clears the command on the next cycle
        if (reg_wr_in) begin
            case (reg_addr_in) // RL20
                `PID_REG_CTRL: st_d.ctrl = reg_wdata_in;
                `PID_REG_KP: st_d.kp = reg_wdata_in;
                `PID_REG_TI: st_d.ti = reg_wdata_in;
                `PID_REG_TD: st_d.td = reg_wdata_in;
                `PID_REG_IBOUND: st_d.ibound = reg_wdata_in;
                `PID_REG_DFILT: st_d.dfilt = reg_wdata_in;
                `PID_REG_OUTLIM: st_d.outlim = reg_wdata_in;
                `PID_REG_LOSS_TIME: st_d.loss_time = reg_wdata_in;
                `PID_REG_LOSS_ACT: st_d.loss_act = reg_wdata_in[1:0];
                `PID_REG_FB_GAIN: st_d.fb_gain = reg_wdata_in;
                `PID_REG_DEV_LEVEL: st_d.dev_level = reg_wdata_in;
                `PID_REG_DEV_WIN: st_d.dev_win = reg_wdata_in;
                `PID_REG_SLEEP_TIME: st_d.sleep_time = reg_wdata_in;
                `PID_REG_SLEEP_FREQ: st_d.sleep_freq = reg_wdata_in;
                `PID_REG_WAKE_FREQ: st_d.wake_freq = reg_wdata_in;
                `PID_REG_DEV_ACT: st_d.dev_act = reg_wdata_in[1:0];
                `PID_REG_MAX_FREQ: st_d.max_freq = reg_wdata_in;
                `PID_REG_MIN_FREQ: st_d.min_freq = reg_wdata_in;
                `PID_REG_PID_MIN: st_d.pid_min = reg_wdata_in; // RL18
                `PID_REG_LOWER_BOUND: st_d.lower_bound = reg_wdata_in;
                `PID_REG_FAULT_FUNC: st_d.fault_func = reg_wdata_in;
                `PID_REG_FB_SCALE: st_d.fb_scale = reg_wdata_in;
                default: st_d.ctrl = st_q.ctrl;
            endcase
        end

        // read data, valid the cycle after the strobe
        if (reg_rd_in) begin
            case (reg_addr_in)
                `PID_REG_CTRL: st_d.rd_data = st_q.ctrl;
                `PID_REG_KP: st_d.rd_data = st_q.kp;
                `PID_REG_TI: st_d.rd_data = st_q.ti;
                `PID_REG_TD: st_d.rd_data = st_q.td;
                `PID_REG_IBOUND: st_d.rd_data = st_q.ibound;
                `PID_REG_DFILT: st_d.rd_data = st_q.dfilt;
                `PID_REG_OUTLIM: st_d.rd_data = st_q.outlim;
                `PID_REG_LOSS_TIME: st_d.rd_data = st_q.loss_time;
                `PID_REG_LOSS_ACT: st_d.rd_data = {14'h0000, st_q.loss_act};
                `PID_REG_FB_GAIN: st_d.rd_data = st_q.fb_gain;
                `PID_REG_DEV_LEVEL: st_d.rd_data = st_q.dev_level;
                `PID_REG_DEV_WIN: st_d.rd_data = st_q.dev_win;
                `PID_REG_SLEEP_TIME: st_d.rd_data = st_q.sleep_time;
                `PID_REG_SLEEP_FREQ: st_d.rd_data = st_q.sleep_freq;
                `PID_REG_WAKE_FREQ: st_d.rd_data = st_q.wake_freq;
                `PID_REG_DEV_ACT: st_d.rd_data = {14'h0000, st_q.dev_act};
                `PID_REG_MAX_FREQ: st_d.rd_data = st_q.max_freq;
                `PID_REG_MIN_FREQ: st_d.rd_data = st_q.min_freq;
                `PID_REG_PID_MIN: st_d.rd_data = st_q.pid_min;
                `PID_REG_LOWER_BOUND: st_d.rd_data = st_q.lower_bound;
                `PID_REG_FAULT_FUNC: st_d.rd_data = st_q.fault_func;
                `PID_REG_FB_SCALE: st_d.rd_data = st_q.fb_scale;
                `PID_REG_STATUS: st_d.rd_data = {10'h000, stop_coast_out, stop_ramp_out, dev_fault_out,
                                                 dev_warn_out, fb_loss_warn_out, sleep_active_out};
                `PID_REG_FREQ_CMD: st_d.rd_data = st_q.freq_cmd;
                `PID_REG_DISPLAY: st_d.rd_data = st_q.display;
                default: st_d.rd_data = 16'h0000;
            endcase
        end

        // display scaling, outside the control path
        st_d.display = 16'(pct_of(16'(fb_gained), st_q.fb_scale, 16'h03e7)); // RL19

        if (!st_q.ctrl[`PID_CTRL_ENABLE]) begin
            st_d.integ = 48'sh0;
            st_d.dfilt_acc = 40'sh0;
            st_d.prev_dev = 32'sh0;
            st_d.freq_cmd = 16'h0000;
            st_d.sleep_state = ST_RUN;
        end else if (tick) begin
            // terms keep updating while asleep
            st_d.integ = i_next; // RL14
            st_d.dfilt_acc = d_next;
            st_d.prev_dev = dev_now; // RL3
            case (st_q.sleep_state)
                ST_RUN: begin
                    if (sleep_en && sleep_exp) begin
                        st_d.sleep_state = ST_SLEEP; // RL12
                    end
                end
                ST_SLEEP: begin
                    if (!sleep_en || wake_exp) begin
                        st_d.sleep_state = ST_RUN; // RL13
                        st_d.accel_from_min = 1'b1; // RL14
                    end
                end
                default: st_d.sleep_state = ST_RUN;
            endcase
            // shape the command around the minimum and lower bound
            if (st_d.sleep_state == ST_SLEEP) begin
                st_d.freq_cmd = 16'h0000; // RL16
            end else if (st_d.accel_from_min) begin
                st_d.freq_cmd = st_q.min_freq; // RL14
            end else if (u_limited < st_q.pid_min) begin
                st_d.freq_cmd = sleep_en ? st_q.lower_bound : 16'h0000; // RL17
            end else if (u_limited <= st_q.lower_bound) begin
                st_d.freq_cmd = st_q.lower_bound; // RL16
            end else begin
                st_d.freq_cmd = u_limited; // RL6
            end
        end
    end

    // state register
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            st_q <= '0;
            st_q.ctrl <= `PID_RST_CTRL;
            st_q.kp <= `PID_RST_KP;
            st_q.ti <= `PID_RST_TI;
            st_q.td <= `PID_RST_TD;
            st_q.ibound <= `PID_RST_IBOUND;
            st_q.dfilt <= `PID_RST_DFILT;
            st_q.outlim <= `PID_RST_OUTLIM;
            st_q.loss_time <= `PID_RST_LOSS_TIME;
            st_q.loss_act <= `PID_RST_LOSS_ACT;
            st_q.fb_gain <= `PID_RST_FB_GAIN;
            st_q.dev_level <= `PID_RST_DEV_LEVEL;
            st_q.dev_win <= `PID_RST_DEV_WIN;
            st_q.sleep_time <= `PID_RST_SLEEP_TIME;
            st_q.max_freq <= `PID_RST_MAX_FREQ;
            st_q.fb_scale <= `PID_RST_FB_SCALE;
            st_q.sleep_state <= ST_RUN;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------

    assign reg_rdata_out = st_q.rd_data;
    assign freq_cmd_out = st_q.freq_cmd;
    assign accel_from_min_out = st_q.accel_from_min;
    assign sleep_active_out = (st_q.sleep_state == ST_SLEEP);
    assign fb_loss_warn_out = loss_exp; // RL7
    assign dev_warn_out = dev_exp; // RL11
    assign dev_fault_out = dev_exp && (st_q.fault_func == `PID_DEV_FAULT_FUNC); // RL11
    // loss 0 ramps, 1 coasts; deviation 1 coasts, 2 ramps
    assign stop_ramp_out = (loss_exp && (st_q.loss_act == 2'h0))
        || (dev_exp && (st_q.dev_act == 2'h2)); // RL8 RL23
    assign stop_coast_out = (loss_exp && (st_q.loss_act == 2'h1))
        || (dev_exp && (st_q.dev_act == 2'h1)); // RL8 RL23
    assign fb_display_out = st_q.display;

endmodule

// File: bench/pid_regulator_sva.sv
`timescale 1ns/1ps
module pid_regulator_sva (
    input wire logic mclk_in, // clock
    input wire logic resetn_in, // reset
    input wire logic reg_rd_in, // read strobe
    input wire logic [15:0] reg_rdata_out, // read data
    input wire logic fb_abnormal_in, // loop fault pin
    input wire logic [15:0] freq_cmd_out, // command
    input wire logic accel_from_min_out, // wake pulse
    input wire logic sleep_active_out, // asleep
    input wire logic fb_loss_warn_out, // loss warning
    input wire logic dev_warn_out, // deviation warning
    input wire logic dev_fault_out, // fault terminal
    input wire logic stop_ramp_out, // ramp stop
    input wire logic stop_coast_out // coast stop
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (!resetn_in);
    // ----------------------------------------
    // port relations
    // ----------------------------------------
    rd_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
        else $error("read data outside answer cycle");
    cmd_hold_a: assert property ($changed(freq_cmd_out) |=> $stable(freq_cmd_out))
        else $error("command changed on consecutive cycles");
    fault_warn_a: assert property (dev_fault_out |-> dev_warn_out)
        else $error("fault terminal without deviation");
    loss_cause_a: assert property ($rose(fb_loss_warn_out) |-> $past(fb_abnormal_in, 3) && $past(fb_abnormal_in, 4))
        else $error("loss warning without abnormal input");
    stop_cause_a: assert property (stop_ramp_out || stop_coast_out |-> fb_loss_warn_out || dev_warn_out)
        else $error("stop request without warning");
    accel_pulse_a: assert property (accel_from_min_out |=> !accel_from_min_out)
        else $error("wake pulse longer than one cycle");
    wake_cause_a: assert property (accel_from_min_out |-> $past(sleep_active_out))
        else $error("wake pulse while awake");
    sleep_zero_a: assert property (sleep_active_out [*3] |-> freq_cmd_out == 16'h0000)
        else $error("nonzero command while asleep");
endmodule
bind pid_frequency_regulator pid_regulator_sva i_sva (.mclk_in, .resetn_in, .reg_rd_in, .reg_rdata_out,
    .fb_abnormal_in, .freq_cmd_out, .accel_from_min_out, .sleep_active_out, .fb_loss_warn_out,
    .dev_warn_out, .dev_fault_out, .stop_ramp_out, .stop_coast_out);

// File: bench/pid_plant_model.sv
`timescale 1ns/1ps
module pid_plant_model (
    input wire logic mclk_in, // clock
    input wire logic resetn_in, // reset
    input wire logic [15:0] cmd_in, // command
    output logic [15:0] actual_out // ramped frequency
);
    // ramp generator: rises in steps, drops at once
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            actual_out <= 16'h0000;
        end else begin
            actual_out <= (cmd_in > actual_out + 16'h0008) ? actual_out + 16'h0008 : cmd_in;
        end
    end
endmodule

// File: bench/pid_frequency_regulator_tb_top.sv
`timescale 1ns/1ps
module pid_frequency_regulator_tb_top;
    localparam int TK = 40;
    logic mclk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [4:0] addr = 5'h00;
    logic [15:0] wdata = 16'h0000, sp = 16'h0000, fb = 16'h0000;
    logic wr = 1'b0, rd = 1'b0, abn = 1'b0;
    logic [15:0] rdata, cmd, act, disp;
    logic acc, slp, lw, dw, df, sr, sc;
    int n_errors = 0;
    int checked = 0;
    logic [4:0] ra[8] = '{5'h02, 5'h04, 5'h06, 5'h07, 5'h09, 5'h0a, 5'h15, 5'h1f};
    logic [15:0] rv[8] = '{16'h0064, 16'h0064, 16'h0064, 16'h0258, 16'h000a, 16'h0064, 16'h03e7, 16'h0000};
    // clock
    always #12.5 mclk_in = ~mclk_in;
    pid_frequency_regulator #(.TICK_CYCLES(TK)) i_dut (.mclk_in, .resetn_in, .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .setpoint_in(sp),
        .feedback_in(fb), .fb_abnormal_in(abn), .actual_freq_in(act), .freq_cmd_out(cmd),
        .accel_from_min_out(acc), .sleep_active_out(slp), .fb_loss_warn_out(lw), .dev_warn_out(dw),
        .dev_fault_out(df), .stop_ramp_out(sr), .stop_coast_out(sc), .fb_display_out(disp));
    pid_plant_model i_plant (.mclk_in, .resetn_in, .cmd_in(cmd), .actual_out(act));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge mclk_in);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input string nm, input logic [4:0] a, input logic [15:0] e);
        @(posedge mclk_in);
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk_in);
        rd <= 1'b0;
        #1 chk(nm, e, rdata);
    endtask
    task automatic tk(input int n);
        repeat (n * TK) @(posedge mclk_in);
        #1;
    endtask
    task automatic summarize;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge mclk_in);
        resetn_in <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd_chk("reset value", ra[i], rv[i]);
        end
        wr_reg(5'h02, 16'h0000);
        wr_reg(5'h00, 16'h0001);
        sp <= 16'h03e8;
        tk(4);
        chk("p only", 16'h03e8, cmd);
        wr_reg(5'h01, 16'h0014);
        tk(3);
        chk("gain while running", 16'h07d0, cmd);
        wr_reg(5'h09, 16'h0014);
        fb <= 16'h00c8;
        tk(3);
        chk("feedback gain", 16'h04b0, cmd);
        chk("display", 16'h0190, disp);
        wr_reg(5'h00, 16'h0003);
        sp <= 16'h0064;
        fb <= 16'h0190;
        tk(3);
        chk("positive polarity", 16'h0578, cmd);
        wr_reg(5'h06, 16'h000a);
        tk(3);
        chk("output limit", 16'h0258, cmd);
        wr_reg(5'h13, 16'h0320);
        tk(3);
        chk("lower bound", 16'h0320, cmd);
        wr_reg(5'h13, 16'h0000);
        sp <= 16'h0000;
        fb <= 16'h0000;
        wr_reg(5'h00, 16'h0009);
        wr_reg(5'h07, 16'h0001);
        abn <= 1'b1;
        tk(110);
        for (int a = 0; a < 3; a++) begin
            wr_reg(5'h08, 16'(a));
            tk(1);
            chk("loss warn", 16'h0001, {15'h0000, lw});
            chk("loss stop", {14'h0000, a == 1, a == 0}, {14'h0000, sc, sr});
        end
        @(posedge mclk_in);
        abn <= 1'b0;
        tk(2);
        chk("loss cleared", 16'h0000, {15'h0000, lw});
        wr_reg(5'h00, 16'h0001);
        wr_reg(5'h0d, 16'h0096);
        wr_reg(5'h0e, 16'h012c);
        wr_reg(5'h0c, 16'h0001);
        sp <= 16'h0032;
        tk(110);
        chk("asleep", 16'h0001, {15'h0000, slp});
        chk("sleep command", 16'h0000, cmd);
        @(posedge mclk_in);
        sp <= 16'h0bb8;
        tk(110);
        chk("awake", 16'h0000, {15'h0000, slp});
        chk("wake command", 16'h0258, cmd);
        wr_reg(5'h0b, 16'h0001);
        wr_reg(5'h14, 16'h0010);
        wr_reg(5'h0f, 16'h0001);
        sp <= 16'h07d0;
        tk(110);
        chk("deviation", 16'h0007, {13'h0000, sc, df, dw});
        wr_reg(5'h0a, 16'h0000);
        tk(2);
        chk("deviation off", 16'h0000, {15'h0000, dw});
        summarize;
    end
    // watchdog
    initial begin
        repeat (60000) @(posedge mclk_in);
        n_errors++;
        summarize;
    end
endmodule
